// >>> hw/efa_top.sv
`timescale 1ns/1ps
`include "efa_cfg.svh"

module efa_top
    import efa_pkg::*;
(
    input  wire logic                          clk_sys,
    input  wire logic                          rst_b,
    input  wire logic                          scan_done,
    input  wire logic                          fault_wr_en,
    input  wire logic [`EFA_FAULT_IDX_W-1:0]   fault_wr_idx,
    input  wire logic [`EFA_FAULT_W-1:0]       fault_wr_data,
    input  wire logic [`EFA_WARN_BITS-1:0]     ext_warn_bits,
    output      efa_faults_t                   ext_fault_code,
    output      efa_list_t                     ext_warn_list,
    output      logic [`EFA_LIST_N-1:0]        ext_warn_valid,
    output      logic                          annunc_err_bit,
    output      logic                          annunc_warn_bit,
    output      logic [`EFA_SYS_W-1:0]         sys_error_word,
    output      logic [`EFA_SYS_W-1:0]         sys_warning_word,
    output      logic                          outputs_off,
    output      logic                          error_stop,
    output      logic                          eval_busy
);

    // ======================================================================
    // Helpers.
    function automatic logic [`EFA_CNT_W-1:0] count_valid(input logic [`EFA_LIST_N-1:0] v);
        logic [`EFA_CNT_W-1:0] c;
        c = '0;
        for (int i = 0; i < `EFA_LIST_N; i++) begin
            c = c + {{(`EFA_CNT_W-1){1'b0}}, v[i]};
        end
        return c;
    endfunction

    function automatic logic [`EFA_WARN_BITS-1:0] listed_mask(input efa_list_t l,
                                                            input logic [`EFA_LIST_N-1:0] v);
        logic [`EFA_WARN_BITS-1:0] m;
        m = '0;
        for (int i = 0; i < `EFA_LIST_N; i++) begin
            if (v[i]) begin
                m[l[i]] = 1'b1;
            end
        end
        return m;
    endfunction

    // ======================================================================
    // State.
    efa_state_s s_reg;
    efa_state_s s_next;
    efa_pick_if pk_if ();

    efa_warn_pick u_pick (
        .pk (pk_if)
    );

    logic [`EFA_CNT_W-1:0] count;
    logic                  any_fault;

    assign count = count_valid(s_reg.valid);
    assign pk_if.pending = s_reg.snap & ~listed_mask(s_reg.list, s_reg.valid);

    always_comb begin
        any_fault = 1'b0;
        for (int i = 0; i < `EFA_FAULT_N; i++) begin
            any_fault = any_fault | (s_reg.faults[i] != `EFA_FAULT_RST);
        end
    end

    always_comb begin
        int k;
        k = 0;
        s_next = s_reg;
        if (fault_wr_en) begin
            s_next.faults[fault_wr_idx] = fault_wr_data;
        end
        case (s_reg.st)
            EFA_IDLE: begin
                if (scan_done) begin
                    // A snapshot keeps the evaluation consistent if the program moves on.
                    s_next.snap = ext_warn_bits;
                    s_next.st   = EFA_COMPACT;
                end
            end
            EFA_COMPACT: begin
                if (any_fault) begin
                    s_next.err = 1'b1;
                end
                s_next.list  = '0;
                s_next.valid = '0;
                for (int i = 0; i < `EFA_LIST_N; i++) begin
                    if (s_reg.valid[i] && s_reg.snap[s_reg.list[i]]) begin
                        s_next.list[k[2:0]]  = s_reg.list[i];
                        s_next.valid[k[2:0]] = 1'b1;
                        k = k + 1;
                    end
                end
                s_next.st = EFA_FILL;
            end
            EFA_FILL: begin
                if (pk_if.found && !s_reg.valid[`EFA_LIST_N-1]) begin
                    s_next.list[count[2:0]]  = pk_if.number;
                    s_next.valid[count[2:0]] = 1'b1;
                end else begin
                    s_next.warn = |s_reg.valid;
                    s_next.st   = EFA_IDLE;
                end
            end
            default: begin
                s_next.st = EFA_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            s_reg <= '{st: EFA_IDLE, default: '0};
        end else begin
            s_reg <= s_next;
        end
    end

    // ======================================================================
    // Outputs.
    // The error stop holds until reset; no software path can lift it.
    assign ext_fault_code   = s_reg.faults;
    assign ext_warn_list    = s_reg.list;
    assign ext_warn_valid   = s_reg.valid;
    assign annunc_err_bit   = s_reg.err;
    assign annunc_warn_bit  = s_reg.warn;
    assign sys_error_word   = {{(`EFA_SYS_W-1){1'b0}}, s_reg.err} << `EFA_ERR_BIT_POS;
    assign sys_warning_word = {{(`EFA_SYS_W-1){1'b0}}, s_reg.warn} << `EFA_WARN_BIT_POS;
    assign outputs_off      = s_reg.err;
    assign error_stop       = s_reg.err;
    assign eval_busy        = (s_reg.st != EFA_IDLE);

    // ======================================================================
    // Checks.
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    sequence s_scan_start;
        scan_done && s_reg.st == EFA_IDLE;
    endsequence

    sequence s_eval_end;
        ##[3:12] s_reg.st == EFA_IDLE;
    endsequence

    a_eval_bounded: assert property (s_scan_start |-> s_eval_end)
        else $error("evaluation did not finish in time");

    a_err_on_fault: assert property (s_scan_start ##1 any_fault |=> annunc_err_bit)
        else $error("non-zero fault code did not raise the error bit");

    a_err_sticky: assert property (annunc_err_bit |=> annunc_err_bit && outputs_off)
        else $error("error stop was lifted");

    a_err_word: assert property (sys_error_word[`EFA_ERR_BIT_POS] == error_stop)
        else $error("error word bit and stop disagree");

    a_no_idle_err: assert property (
        s_reg.st == EFA_IDLE && !annunc_err_bit |=> !annunc_err_bit)
        else $error("error raised outside evaluation");

    a_list_packed: assert property ((ext_warn_valid & (ext_warn_valid + 8'h01)) == 8'h00)
        else $error("warning list has a gap");

    a_fill_lowest: assert property (
        s_reg.st == EFA_FILL && pk_if.found && !ext_warn_valid[7]
        |=> ext_warn_list[$past(count[2:0])] == $past(pk_if.number))
        else $error("new warning not placed at list end");

    // Shifting the pending set up by 128 minus the picked number leaves only lower bits behind.
    a_pick_lowest: assert property (
        pk_if.found |-> pk_if.pending[pk_if.number]
        && (pk_if.pending << (`EFA_WARN_BITS - 32'(pk_if.number))) == '0)
        else $error("picked warning is not the lowest pending one");

    a_full_holds: assert property (
        s_reg.st == EFA_FILL && ext_warn_valid[7]
        |=> $stable(ext_warn_list))
        else $error("full list was changed");

    a_held_ahead: assert property (
        s_reg.st == EFA_FILL && ext_warn_valid[0]
        |=> $stable(ext_warn_list[0]))
        else $error("held warning displaced by new one");

    a_warn_bit: assert property (
        s_reg.st == EFA_FILL ##1 s_reg.st == EFA_IDLE
        |-> annunc_warn_bit == (|ext_warn_valid))
        else $error("warning bit disagrees with list");

    a_release_drop: assert property (
        s_reg.st == EFA_COMPACT && ext_warn_valid[0]
        && !s_reg.snap[ext_warn_list[0]] |=> ext_warn_list[0] != $past(ext_warn_list[0])
        || !ext_warn_valid[0])
        else $error("released warning stayed at entry 0");

endmodule

// >>> pkg/efa_cfg.svh
`ifndef EFA_CFG_SVH
`define EFA_CFG_SVH

// ==========================================================================
// Array sizes.
`define EFA_FAULT_N      16
`define EFA_FAULT_W      16
`define EFA_FAULT_IDX_W  4
`define EFA_WARN_BITS    128
`define EFA_WARN_NUM_W   7
`define EFA_LIST_N       8
`define EFA_CNT_W        4

// ==========================================================================
// Bit positions of the annunciator bits within the system words.
`define EFA_ERR_BIT_POS  4'd8
`define EFA_WARN_BIT_POS 4'd8
`define EFA_SYS_W        16

// ==========================================================================
// Reset values.
`define EFA_FAULT_RST    16'h0000
`define EFA_NUM_RST      7'h00

`endif

// >>> pkg/efa_pkg.sv
`include "efa_cfg.svh"

package efa_pkg;

    typedef enum logic [1:0] {
        EFA_IDLE,
        EFA_COMPACT,
        EFA_FILL
    } efa_state_e;

    typedef logic [`EFA_WARN_NUM_W-1:0]                   efa_num_t;
    typedef logic [`EFA_LIST_N-1:0][`EFA_WARN_NUM_W-1:0]  efa_list_t;
    typedef logic [`EFA_FAULT_N-1:0][`EFA_FAULT_W-1:0]    efa_faults_t;

    typedef struct packed {
        efa_state_e                 st;
        efa_faults_t                faults;
        logic [`EFA_WARN_BITS-1:0]  snap;
        efa_list_t                  list;
        logic [`EFA_LIST_N-1:0]     valid;
        logic                       err;
        logic                       warn;
    } efa_state_s;

endpackage

// >>> pkg/efa_pick_if.sv
`timescale 1ns/1ps
`include "efa_cfg.svh"

interface efa_pick_if;
    logic [`EFA_WARN_BITS-1:0]  pending;
    logic                       found;
    logic [`EFA_WARN_NUM_W-1:0] number;

    modport req  (output pending, input found, input number);
    modport pick (input pending, output found, output number);
endinterface

// >>> hw/efa_warn_pick.sv
`timescale 1ns/1ps
`include "efa_cfg.svh"

// ==========================================================================
// Lowest-numbered pending warning wins, so new warnings of one scan enter
// the list in ascending order.
module efa_warn_pick
    import efa_pkg::*;
(
    efa_pick_if.pick pk
);

    always_comb begin
        pk.found  = 1'b0;
        pk.number = `EFA_NUM_RST;
        for (int i = `EFA_WARN_BITS - 1; i >= 0; i--) begin
            if (pk.pending[i]) begin
                pk.found  = 1'b1;
                pk.number = efa_num_t'(i);
            end
        end
    end

endmodule

// >>> tb/efa_prog.sv
`timescale 1ns/1ps
`include "efa_cfg.svh"

// ==========================================================================
// User program stand-in. A scan is ended only while the block is idle,
// because a pulse during evaluation would be dropped without notice.
module efa_prog (
    input  wire logic                        clk_sys,
    input  wire logic                        eval_busy,
    output      logic                        scan_done,
    output      logic                        fault_wr_en,
    output      logic [`EFA_FAULT_IDX_W-1:0] fault_wr_idx,
    output      logic [`EFA_FAULT_W-1:0]     fault_wr_data,
    output      logic [`EFA_WARN_BITS-1:0]   ext_warn_bits
);
    initial begin
        scan_done = 1'b0;
        fault_wr_en = 1'b0;
        fault_wr_idx = 4'h0;
        fault_wr_data = 16'h0000;
        ext_warn_bits = '0;
    end

    task automatic write_fault(input logic [3:0] idx, input logic [15:0] code);
        @(posedge clk_sys);
        #1;
        fault_wr_en = 1'b1;
        fault_wr_idx = idx;
        fault_wr_data = code;
        @(posedge clk_sys);
        #1;
        fault_wr_en = 1'b0;
        fault_wr_idx = ~idx;
        fault_wr_data = ~code;
    endtask

    task automatic scan(input logic [`EFA_WARN_BITS-1:0] bits, output logic ok);
        int n;
        n = 0;
        @(posedge clk_sys);
        #1;
        ext_warn_bits = bits;
        scan_done = 1'b1;
        @(posedge clk_sys);
        #1;
        scan_done = 1'b0;
        while (eval_busy !== 1'b0 && n < 20) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        ok = (n < 20);
    endtask
endmodule

// >>> tb/testbench.sv
`timescale 1ns/1ps
`include "efa_cfg.svh"

module testbench
    import efa_pkg::*;
;
    logic                        clk_sys = 1'b0;
    logic                        rst_b = 1'b0;
    logic                        scan_done;
    logic                        fault_wr_en;
    logic [`EFA_FAULT_IDX_W-1:0] fault_wr_idx;
    logic [`EFA_FAULT_W-1:0]     fault_wr_data;
    logic [`EFA_WARN_BITS-1:0]   ext_warn_bits;
    efa_faults_t                 ext_fault_code;
    efa_list_t                   ext_warn_list;
    logic [`EFA_LIST_N-1:0]      ext_warn_valid;
    logic                        annunc_err_bit;
    logic                        annunc_warn_bit;
    logic [`EFA_SYS_W-1:0]       sys_error_word;
    logic [`EFA_SYS_W-1:0]       sys_warning_word;
    logic                        outputs_off;
    logic                        error_stop;
    logic                        eval_busy;
    int                          n_mismatch = 0;
    int                          samples_checked = 0;

    always #20 clk_sys = ~clk_sys;

    efa_top efa_top_i (.clk_sys(clk_sys), .rst_b(rst_b), .scan_done(scan_done),
        .fault_wr_en(fault_wr_en), .fault_wr_idx(fault_wr_idx),
        .fault_wr_data(fault_wr_data), .ext_warn_bits(ext_warn_bits),
        .ext_fault_code(ext_fault_code), .ext_warn_list(ext_warn_list),
        .ext_warn_valid(ext_warn_valid), .annunc_err_bit(annunc_err_bit),
        .annunc_warn_bit(annunc_warn_bit), .sys_error_word(sys_error_word),
        .sys_warning_word(sys_warning_word), .outputs_off(outputs_off),
        .error_stop(error_stop), .eval_busy(eval_busy));

    efa_prog efa_prog_i (.clk_sys(clk_sys), .eval_busy(eval_busy), .scan_done(scan_done),
        .fault_wr_en(fault_wr_en), .fault_wr_idx(fault_wr_idx),
        .fault_wr_data(fault_wr_data), .ext_warn_bits(ext_warn_bits));

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t ns got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [`EFA_WARN_BITS-1:0] wb(input int n);
        logic [`EFA_WARN_BITS-1:0] b;
        b = '0;
        b[n] = 1'b1;
        return b;
    endfunction

    function automatic efa_list_t lst(input int a0, input int a1, input int a2, input int a3,
                                      input int a4, input int a5, input int a6, input int a7);
        return {7'(a7), 7'(a6), 7'(a5), 7'(a4), 7'(a3), 7'(a2), 7'(a1), 7'(a0)};
    endfunction

    task automatic do_scan(input logic [`EFA_WARN_BITS-1:0] bits);
        logic ok;
        efa_prog_i.scan(bits, ok);
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("[ERR] %0t ns evaluation did not finish", $time);
            finish_test();
        end
    endtask

    // Empty entries read zero; the valid flags tell number 0 from an empty slot.
    task automatic chk_warn(input efa_list_t l, input logic [7:0] v);
        chk(64'(ext_warn_list), 64'(l));
        chk(64'(ext_warn_valid), 64'(v));
        chk(64'(annunc_warn_bit), 64'(v != 8'h00));
        chk(64'(sys_warning_word), 64'({v != 8'h00, 8'h00}));
    endtask

    task automatic t_reset();
        chk(64'({annunc_err_bit, error_stop, outputs_off, eval_busy}), 64'h0);
        chk(64'(sys_error_word), 64'h0);
        chk_warn(lst(0, 0, 0, 0, 0, 0, 0, 0), 8'h00);
    endtask

    task automatic t_warn_list();
        logic [`EFA_WARN_BITS-1:0] b;
        b = wb(1) | wb(2) | wb(3) | wb(15) | wb(40) | wb(50) | wb(60) | wb(75);
        do_scan(wb(10));
        chk_warn(lst(10, 0, 0, 0, 0, 0, 0, 0), 8'h01);
        do_scan(b | wb(10));
        chk_warn(lst(10, 1, 2, 3, 15, 40, 50, 60), 8'hff);
        do_scan(b);
        chk_warn(lst(1, 2, 3, 15, 40, 50, 60, 75), 8'hff);
        do_scan('0);
        chk_warn(lst(0, 0, 0, 0, 0, 0, 0, 0), 8'h00);
        do_scan(wb(0) | wb(127));
        chk_warn(lst(0, 127, 0, 0, 0, 0, 0, 0), 8'h03);
    endtask

    task automatic t_fault();
        efa_prog_i.write_fault(4'h0, 16'h0001);
        efa_prog_i.write_fault(4'hf, 16'hffff);
        chk(64'(ext_fault_code[0]), 64'h1);
        chk(64'(ext_fault_code[15]), 64'hffff);
        chk(64'(annunc_err_bit), 64'h0);
        do_scan('0);
        chk(64'({annunc_err_bit, outputs_off, error_stop}), 64'h7);
        chk(64'(sys_error_word), 64'h0100);
        efa_prog_i.write_fault(4'h0, 16'h0000);
        efa_prog_i.write_fault(4'hf, 16'h0000);
        do_scan('0);
        chk(64'({annunc_err_bit, error_stop}), 64'h3);
    endtask

    // Only a reset lifts the error stop; it must also empty the list and the fault array.
    task automatic t_mid_reset();
        efa_prog_i.write_fault(4'h3, 16'h0005);
        do_scan(wb(5));
        chk(64'(ext_fault_code[3]), 64'h5);
        chk_warn(lst(5, 0, 0, 0, 0, 0, 0, 0), 8'h01);
        @(posedge clk_sys);
        #1;
        rst_b = 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
        rst_b = 1'b1;
        t_reset();
        chk(64'(ext_fault_code[3]), 64'h0);
        do_scan(wb(5));
        chk_warn(lst(5, 0, 0, 0, 0, 0, 0, 0), 8'h01);
        chk(64'({annunc_err_bit, error_stop}), 64'h0);
    endtask

    initial begin
        repeat (2) @(posedge clk_sys);
        #1;
        rst_b = 1'b1;
        t_reset();
        t_warn_list();
        t_fault();
        t_mid_reset();
        finish_test();
    end
endmodule
